// File: logic/tws_cfg.svh
// Constants of the three-wire serial shift unit: field positions, reset values, timing.
// Assumes inclusion by bare name from the package and both design ends.
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// Control register fields
`define TWS_CR_WM_HI 5
`define TWS_CR_WM_LO 4
`define TWS_CR_CS1 3
`define TWS_CR_CS0 2
`define TWS_CR_CLK 1
`define TWS_CR_TC 0
`define TWS_WM_THREE_WIRE 2'h1
`define TWS_CR_RESET 8'h00

// Status register fields
`define TWS_SR_OIF 7
`define TWS_SR_CNT_HI 3
`define TWS_SR_CNT_LO 0
`define TWS_CNT_LAST 4'hF

// Port and direction bit positions
`define TWS_PORT_DO 1
`define TWS_PORT_SCK 2
`define TWS_PORT_RESET 8'h00

// Timing: clock rate and least half period of the generated serial clock
`define TWS_CLK_MHZ 10
`define TWS_HALF_NS 400
`define TWS_HALF_CYC ((`TWS_HALF_NS * `TWS_CLK_MHZ + 999) / 1000)
`define TWS_EDGES_PER_BYTE 5'h10

`endif

// File: logic/tws_pkg.sv
// Types shared by both ends of the three-wire serial link.
// Assumes tws_cfg.svh is on the include path.
`default_nettype none
`include "tws_cfg.svh"

package tws_pkg;
    typedef logic [7:0] tws_byte_t;
    typedef logic [3:0] tws_cnt_t;
    // Peer sequencer states, Gray along idle, setup, run, done
    typedef enum logic [1:0] {
        TWS_IDLE = 2'h0,
        TWS_SETUP = 2'h1,
        TWS_RUN = 2'h3,
        TWS_DONE = 2'h2
    } tws_state_e;
endpackage

`default_nettype wire

// File: logic/tws_if.sv
// Three-wire link between the shift unit (dev) and its peer (peer).
// Each pin is output plus enable per end; an undriven line reads low.
`default_nettype none

interface tws_if;
    logic dev_sck_o;
    logic dev_sck_oe;
    logic dev_do_o;
    logic dev_do_oe;
    logic peer_sck_o;
    logic peer_sck_oe;
    logic peer_do_o;
    logic peer_do_oe;
    logic sck;
    logic dev_di;
    logic peer_di;

    assign sck = dev_sck_oe ? dev_sck_o : (peer_sck_oe ? peer_sck_o : 1'b0);
    assign dev_di = peer_do_oe ? peer_do_o : 1'b0;
    assign peer_di = dev_do_oe ? dev_do_o : 1'b0;

    modport dev (
        output dev_sck_o, dev_sck_oe, dev_do_o, dev_do_oe,
        input sck, dev_di
    );
    modport peer (
        output peer_sck_o, peer_sck_oe, peer_do_o, peer_do_oe,
        input sck, peer_di
    );
endinterface

`default_nettype wire

// File: logic/tws_unit.sv
// Three-wire serial shift unit: 8-bit shift register, 4-bit edge counter, port pin logic.
// Assumes i_clk well above the link clock; sck and data-in are synchronised here.
`default_nettype none
`include "tws_cfg.svh"

module tws_unit (
    input wire logic i_clk,                    // System clock
    input wire logic i_rst,                    // Async reset, active high
    tws_if.dev link,                           // Link pins
    input wire logic i_ctrl_wr,                // Control register write strobe
    input wire logic [7:0] i_ctrl_wdata,       // Control write data
    input wire logic i_data_wr,                // Shift register write strobe
    input wire logic [7:0] i_data_wdata,       // Shift register write data
    input wire logic i_stat_wr,                // Status register write strobe
    input wire logic [7:0] i_stat_wdata,       // Status write data
    input wire logic i_port_wr,                // Port output register write strobe
    input wire logic [7:0] i_port_wdata,       // Port output write data
    input wire logic [7:0] i_ddr,              // Port direction bits, 1 drives
    input wire logic i_timer_ovf,              // Timer overflow pulse
    input wire logic i_ovf_ie,                 // Overflow interrupt enable
    output logic [7:0] o_ctrl,                 // Control register readback
    output logic [7:0] o_data,                 // Shift register readback
    output logic [7:0] o_status,               // Status register readback
    output logic [7:0] o_port,                 // Port output register readback
    output logic o_wake                        // Overflow wake request
);
    logic [1:0] wmode;
    logic cs1;
    logic cs0;
    logic clk_sel;
    tws_pkg::tws_byte_t shreg;
    tws_pkg::tws_cnt_t cnt;
    logic oif;
    logic [7:0] port;
    logic do_hold;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic di_s1;
    logic di_s2;

    // Selects the edge that matches the clock edge select bit
    function automatic logic pick_edge(input logic sel, input logic rise, input logic fall);
        pick_edge = sel ? fall : rise;
    endfunction

    wire sck_rise = sck_s2 & ~sck_s3;
    wire sck_fall = ~sck_s2 & sck_s3;
    wire three_wire = (wmode == `TWS_WM_THREE_WIRE);
    wire ext_clk = cs1;
    wire sample_ext = ext_clk & pick_edge(cs0, sck_rise, sck_fall);
    wire change_ext = ext_clk & pick_edge(cs0, sck_fall, sck_rise);
    wire wr_cs1 = i_ctrl_wdata[`TWS_CR_CS1];
    wire wr_cs0 = i_ctrl_wdata[`TWS_CR_CS0];
    wire soft_strobe = i_ctrl_wr & i_ctrl_wdata[`TWS_CR_CLK] & ~wr_cs1 & ~wr_cs0;
    wire tc_write = i_ctrl_wr & i_ctrl_wdata[`TWS_CR_TC];
    wire tc_count = tc_write & wr_cs1 & i_ctrl_wdata[`TWS_CR_CLK];
    wire timer_clk = ~cs1 & cs0 & i_timer_ovf;
    wire shift_en = soft_strobe | timer_clk | sample_ext;
    wire edge_count = ext_clk & ~clk_sel & (sck_rise | sck_fall);
    wire cnt_en = soft_strobe | timer_clk | edge_count | tc_count;
    wire ovf_set = cnt_en & (cnt == `TWS_CNT_LAST);
    wire oif_clr = i_stat_wr & i_stat_wdata[`TWS_SR_OIF];
    wire next_oif = ovf_set | (oif & ~oif_clr);
    wire [3:0] cnt_inc = cnt + 4'h1;
    wire [3:0] next_cnt = i_stat_wr ? i_stat_wdata[`TWS_SR_CNT_HI:`TWS_SR_CNT_LO]
                                    : (cnt_en ? cnt_inc : cnt);
    wire [7:0] next_shreg = i_data_wr ? i_data_wdata
                                      : (shift_en ? {shreg[6:0], di_s2} : shreg);
    // The output latch is open while the clock sits in the change phase, so a byte
    // written before the first sampling edge shows at once; other sources are transparent.
    wire latch_open = ~ext_clk | (sck_s2 == cs0);
    wire do_bit = latch_open ? shreg[7] : do_hold;
    wire next_do_pin = three_wire ? do_bit : port[`TWS_PORT_DO];
    wire next_sck_port = tc_write ^ port[`TWS_PORT_SCK];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            di_s1 <= 1'b0;
            di_s2 <= 1'b0;
        end else begin
            sck_s1 <= link.sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            di_s1 <= link.dev_di;
            di_s2 <= di_s1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wmode <= 2'(`TWS_CR_RESET >> `TWS_CR_WM_LO);
            cs1 <= 1'b0;
            cs0 <= 1'b0;
            clk_sel <= 1'b0;
        end else if (i_ctrl_wr) begin
            wmode <= i_ctrl_wdata[`TWS_CR_WM_HI:`TWS_CR_WM_LO];
            cs1 <= wr_cs1;
            cs0 <= wr_cs0;
            clk_sel <= i_ctrl_wdata[`TWS_CR_CLK];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            shreg <= 8'h00;
            cnt <= 4'h0;
            oif <= 1'b0;
            do_hold <= 1'b0;
        end else begin
            shreg <= next_shreg;
            cnt <= next_cnt;
            oif <= next_oif;
            do_hold <= do_bit;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            port <= `TWS_PORT_RESET;
        end else if (i_port_wr) begin
            port <= i_port_wdata;
        end else begin
            port[`TWS_PORT_SCK] <= next_sck_port;
        end
    end

    // Pin drivers follow the direction bits; the unit never enables a driver itself
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            link.dev_do_o <= 1'b0;
            link.dev_do_oe <= 1'b0;
            link.dev_sck_o <= 1'b0;
            link.dev_sck_oe <= 1'b0;
        end else begin
            link.dev_do_o <= next_do_pin;
            link.dev_do_oe <= i_ddr[`TWS_PORT_DO];
            link.dev_sck_o <= port[`TWS_PORT_SCK];
            link.dev_sck_oe <= i_ddr[`TWS_PORT_SCK];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ctrl <= `TWS_CR_RESET;
            o_data <= 8'h00;
            o_status <= 8'h00;
            o_port <= `TWS_PORT_RESET;
            o_wake <= 1'b0;
        end else begin
            // Strobe bits read as zero
            o_ctrl <= {2'h0, wmode, cs1, cs0, 2'h0};
            o_data <= shreg;
            o_status <= {oif, 3'h0, cnt};
            o_port <= port;
            o_wake <= oif & i_ovf_ie;
        end
    end
endmodule

`default_nettype wire

// File: logic/tws_peer.sv
// Peer end of the three-wire link: exchanges one byte as master or slave.
// Assumes the unit end sits on the same tws_if; sck and data-in are synchronised here.
`default_nettype none
`include "tws_cfg.svh"

module tws_peer (
    input wire logic i_clk,              // System clock
    input wire logic i_rst,              // Async reset, active high
    tws_if.peer link,                    // Link pins
    input wire logic i_master,           // 1: peer generates the serial clock
    input wire logic i_mode1,            // 1: clock idles high (mode 1)
    input wire logic i_start,            // Start pulse, taken when idle
    input wire logic [7:0] i_tx,         // Byte to send
    output logic [7:0] o_rx,             // Byte received
    output logic o_done,                 // One-cycle completion pulse
    output logic o_busy                  // Transfer in progress
);
    localparam logic [7:0] HALF = 8'(`TWS_HALF_CYC);

    tws_pkg::tws_state_e state;
    tws_pkg::tws_byte_t sh;
    logic rx_bit;
    logic [4:0] edges;
    logic [4:0] toggles;
    logic [7:0] tmr;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic di_s1;
    logic di_s2;

    wire line_edge = sck_s2 ^ sck_s3;
    wire first_toggle = ~edges[0];
    wire tmr_done = (tmr == 8'h00);
    wire gen_toggle = i_master & (state == tws_pkg::TWS_RUN) & tmr_done
                      & (toggles != `TWS_EDGES_PER_BYTE);
    wire byte_end = (edges == `TWS_EDGES_PER_BYTE);
    wire [4:0] edges_inc = edges + 5'h01;
    wire [4:0] toggles_inc = toggles + 5'h01;
    wire [7:0] tmr_dec = tmr - 8'h01;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            di_s1 <= 1'b0;
            di_s2 <= 1'b0;
        end else begin
            sck_s1 <= link.sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            di_s1 <= link.peer_di;
            di_s2 <= di_s1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= tws_pkg::TWS_IDLE;
            sh <= 8'h00;
            rx_bit <= 1'b0;
            edges <= 5'h00;
            toggles <= 5'h00;
            tmr <= 8'h00;
            link.peer_sck_o <= 1'b0;
            link.peer_sck_oe <= 1'b0;
            link.peer_do_o <= 1'b0;
            link.peer_do_oe <= 1'b0;
            o_rx <= 8'h00;
            o_done <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state)
                tws_pkg::TWS_IDLE: begin
                    link.peer_sck_o <= i_mode1;
                    link.peer_sck_oe <= i_master;
                    if (i_start) begin
                        sh <= i_tx;
                        link.peer_do_o <= i_tx[7];
                        link.peer_do_oe <= 1'b1;
                        edges <= 5'h00;
                        toggles <= 5'h00;
                        tmr <= HALF;
                        o_busy <= 1'b1;
                        state <= tws_pkg::TWS_SETUP;
                    end
                end
                tws_pkg::TWS_SETUP: begin
                    // Hold data at least half a clock period before the first edge
                    if (tmr_done) begin
                        tmr <= HALF;
                        state <= tws_pkg::TWS_RUN;
                    end else begin
                        tmr <= tmr_dec;
                    end
                end
                tws_pkg::TWS_RUN: begin
                    if (gen_toggle) begin
                        link.peer_sck_o <= ~link.peer_sck_o;
                        toggles <= toggles_inc;
                        tmr <= HALF;
                    end else if (!tmr_done) begin
                        tmr <= tmr_dec;
                    end
                    if (line_edge) begin
                        edges <= edges_inc;
                        if (first_toggle) begin
                            rx_bit <= di_s2;
                        end else begin
                            sh <= {sh[6:0], rx_bit};
                            link.peer_do_o <= sh[6];
                        end
                    end
                    if (byte_end) begin
                        state <= tws_pkg::TWS_DONE;
                    end
                end
                tws_pkg::TWS_DONE: begin
                    o_rx <= sh;
                    o_done <= 1'b1;
                    o_busy <= 1'b0;
                    link.peer_do_oe <= 1'b0;
                    state <= tws_pkg::TWS_IDLE;
                end
                default: begin
                    state <= tws_pkg::TWS_IDLE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// File: tb/tws_checker.sv
// Link checker: timing relations on the three-wire link between unit and peer.
// Assumes one clock domain; the bench instantiates it beside the link interface.
`default_nettype none

module tws_checker (
    input wire logic i_clk,       // System clock
    input wire logic i_rst,       // Async reset, active high
    input wire logic dev_sck_oe,  // Unit drives sck
    input wire logic peer_sck_oe, // Peer drives sck
    input wire logic peer_do_oe,  // Peer drives its data out
    input wire logic sck,         // Resolved serial clock
    input wire logic dev_di,      // Data into the unit
    input wire logic peer_di      // Data into the peer
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic sck_q;
    logic [4:0] edge_cnt;
    wire sck_moved = (sck != sck_q);

    // Edges seen while the peer takes part in a frame
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_q <= 1'h0;
            edge_cnt <= 5'h00;
        end else begin
            sck_q <= sck;
            edge_cnt <= !peer_do_oe ? 5'h00 : edge_cnt + {4'h0, sck_moved};
        end
    end

    sequence s_frame_open;
        $rose(peer_do_oe);
    endsequence
    sequence s_sck_quiet;
        $stable(sck) [*4];
    endsequence

    a_sck_one_driver: assert property (!(dev_sck_oe && peer_sck_oe))
        else $error("both ends drive sck");
    a_sck_half_min: assert property ($changed(sck) |=> $stable(sck) [*3])
        else $error("sck half period too short");
    a_unit_in_hold: assert property ($changed(sck) |=> $stable(dev_di) [*2])
        else $error("unit data in moved at sck edge");
    a_peer_in_hold: assert property ($changed(sck) |=> $stable(peer_di) [*2])
        else $error("peer data in moved at sck edge");
    a_setup_lead: assert property (s_frame_open |-> s_sck_quiet)
        else $error("sck moved before data setup");
    a_sixteen_edges: assert property ($fell(peer_do_oe) |-> edge_cnt == 5'h10)
        else $error("frame edge count not sixteen");
    a_idle_sck_still: assert property (peer_sck_oe && $past(peer_sck_oe) && !peer_do_oe
        && !$past(peer_do_oe) |-> $stable(sck))
        else $error("sck moved while peer idle");
    a_frame_length: assert property ($rose(peer_do_oe) && peer_sck_oe
        |-> ##[70:140] $fell(peer_do_oe))
        else $error("master frame length wrong");
endmodule

`default_nettype wire

// File: tb/tws_unit_tb.sv
// Bench: shift unit and peer joined by the link, register writes and byte exchanges.
// Assumes the design files and tws_cfg.svh are compiled first.
`default_nettype none

module tws_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] wr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] ddr = 8'h00;
    logic ovf_ie = 1'h0;
    logic tmr_ovf = 1'h0;
    logic master = 1'h0;
    logic mode1 = 1'h0;
    logic start = 1'h0;
    logic [7:0] tx = 8'h00;
    logic [7:0] ctrl, data, status, port, rx;
    logic wake, done;
    logic [7:0] dev_b [2] = '{8'h3C, 8'h96};
    logic [7:0] peer_b [2] = '{8'hC3, 8'h5A};
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    tws_if lnk();

    tws_unit i_tws_unit (.i_clk(clk), .i_rst(rst), .link(lnk.dev),
        .i_ctrl_wr(wr[0]), .i_ctrl_wdata(wdata), .i_data_wr(wr[1]), .i_data_wdata(wdata),
        .i_stat_wr(wr[2]), .i_stat_wdata(wdata), .i_port_wr(wr[3]), .i_port_wdata(wdata),
        .i_ddr(ddr), .i_timer_ovf(tmr_ovf), .i_ovf_ie(ovf_ie), .o_ctrl(ctrl), .o_data(data),
        .o_status(status), .o_port(port), .o_wake(wake));
    tws_peer i_tws_peer (.i_clk(clk), .i_rst(rst), .link(lnk.peer), .i_master(master),
        .i_mode1(mode1), .i_start(start), .i_tx(tx), .o_rx(rx), .o_done(done), .o_busy());
    tws_checker i_tws_checker (.i_clk(clk), .i_rst(rst), .dev_sck_oe(lnk.dev_sck_oe),
        .peer_sck_oe(lnk.peer_sck_oe), .peer_do_oe(lnk.peer_do_oe), .sck(lnk.sck),
        .dev_di(lnk.dev_di), .peer_di(lnk.peer_di));

    always #50 clk = ~clk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Run is about 410 cycles; the ceiling leaves ample room
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Extra edge after the pulse keeps strobes from being driven twice in one step
    task automatic wr_reg(input int sel, input logic [7:0] val);
        wr[sel] <= 1'h1;
        wdata <= val;
        @(posedge clk);
        wr <= 4'h0;
        @(posedge clk);
    endtask

    task automatic peer_go(input logic [7:0] b);
        tx <= b;
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
    endtask

    task automatic wait_done();
        int k;
        k = 0;
        while (done !== 1'h1 && k < 300) begin
            @(posedge clk);
            k++;
        end
        chk("peer done", 8'h01, {7'h00, done});
    endtask

    initial begin
        int i;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        tick(2);
        chk("ctrl reset", 8'h00, ctrl);
        chk("status reset", 8'h00, status);
        ddr <= 8'h02;
        // Three-wire mode first, so the shift output owns the data pin
        wr_reg(0, 8'h10);
        wr_reg(1, 8'hA5);
        tick(1);
        chk("data load", 8'hA5, data);
        chk("do pin", 8'h01, {7'h00, lnk.peer_di});
        wr_reg(2, 8'h80);
        for (i = 1; i <= 8; i++) begin
            wr_reg(0, 8'h12);
            tick(1);
            chk("strobe shift", 8'(8'hA5 << i), data);
            chk("strobe count", 8'(i), status);
        end
        chk("ctrl readback", 8'h10, ctrl);
        ovf_ie <= 1'h1;
        wr_reg(2, 8'h0E);
        wr_reg(0, 8'h12);
        wr_reg(0, 8'h12);
        tick(1);
        chk("overflow", 8'h80, status);
        chk("wake", 8'h01, {7'h00, wake});
        wr_reg(2, 8'h00);
        tick(1);
        chk("flag sticky", 8'h80, status);
        wr_reg(2, 8'h80);
        tick(1);
        chk("flag clear", 8'h00, status);
        chk("wake off", 8'h00, {7'h00, wake});
        // Timer overflow as clock source
        wr_reg(0, 8'h14);
        wr_reg(2, 8'h00);
        repeat (3) begin
            tmr_ovf <= 1'h1;
            tick(1);
            tmr_ovf <= 1'h0;
            tick(1);
        end
        tick(2);
        chk("timer count", 8'h03, status);
        // Unit as slave in modes 0 and 1; mode changes only while the peer is no master
        for (i = 0; i < 2; i++) begin
            master <= 1'h0;
            tick(2);
            mode1 <= i[0];
            tick(2);
            master <= 1'h1;
            tick(4);
            wr_reg(0, {4'h1, 1'h1, i[0], 2'h0});
            wr_reg(2, 8'h80);
            wr_reg(1, dev_b[i]);
            peer_go(peer_b[i]);
            wait_done();
            tick(6);
            chk("slave rx", peer_b[i], data);
            chk("peer rx", dev_b[i], rx);
            chk("slave flag", 8'h80, status);
        end
        // Unit as master, clock made by toggle writes that also count
        master <= 1'h0;
        tick(2);
        mode1 <= 1'h0;
        ddr <= 8'h06;
        tick(2);
        wr_reg(0, 8'h1A);
        wr_reg(2, 8'h80);
        wr_reg(1, 8'hE7);
        peer_go(8'h29);
        tick(6);
        for (i = 0; i < 16; i++) begin
            wr_reg(0, 8'h1B);
            if (i < 15) begin
                tick(4);
            end
        end
        wait_done();
        tick(6);
        chk("master rx", 8'h29, data);
        chk("slave got", 8'hE7, rx);
        chk("toggle count", 8'h80, status);
        chk("sck port bit", 8'h00, port);
        stop_test();
    end
endmodule

`default_nettype wire
